// file: rtl/link_output_selftest.sv
// Purpose: output pin states from lock and enables, plus self-test control
// Assumes: lock and activity come from the recovery logic, inputs synchronous
// Notes: one ref_clk cycle models a whole pixel period on the status pin
`timescale 1ns/1ps
`include "link_selftest_cfg.svh"
module link_output_selftest (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic chip_enable_in,
	input wire logic output_drive_enable,
	input wire logic idle_output_state_select,
	input wire logic selftest_enable_pin,
	input wire logic [1:0] clk_sel_pins,
	input wire link_selftest_pkg::link_mode_e link_mode,
	input wire logic cdr_locked,
	input wire logic serial_active,
	input wire logic remote_in_selftest,
	input wire logic pclk_in,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic word_valid,
	input wire logic [`DATA_W-1:0] word_in,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output link_selftest_pkg::pin_out_s pin_out,
	output link_selftest_pkg::pin_oe_s pin_oe,
	output logic remote_selftest_cmd,
	output link_selftest_pkg::selftest_clk_e selftest_clk_src,
	output logic [7:0] selftest_freq_mhz,
	output logic selftest_active
);
	link_selftest_pkg::selftest_state_e state_ff;
	link_selftest_pkg::selftest_state_e nxt_state;
	logic [7:0] ctrl_ff;
	logic [7:0] errcnt_ff;
	logic [1:0] result_cnt_ff;
	logic err_pulse_ff;
	logic locked_ff;
	logic frame_err;
	logic st_req;
	logic check_en;
	logic [1:0] clk_code;
	link_selftest_pkg::pin_out_s nxt_out;
	link_selftest_pkg::pin_oe_s nxt_oe;

	// register copy of the clock code only matters in register configuration
	function automatic link_selftest_pkg::selftest_clk_e decode_clk(input logic [1:0] code);
		unique case (code)
			2'b00: decode_clk = link_selftest_pkg::CLK_PIXEL;
			2'b01: decode_clk = link_selftest_pkg::CLK_OSC_HIGH;
			2'b10: decode_clk = link_selftest_pkg::CLK_OSC_LOW;
			2'b11: decode_clk = link_selftest_pkg::CLK_RESERVED;
		endcase
	endfunction : decode_clk

	// nominal oscillator rate in MHz, rounded down; 0 means pixel clock or reserved
	function automatic logic [7:0] osc_freq(input link_selftest_pkg::selftest_clk_e src,
		input link_selftest_pkg::link_mode_e mode, input logic from_reg);
		osc_freq = 8'h00;
		if (!from_reg)
		begin
			if (src == link_selftest_pkg::CLK_OSC_HIGH)
				osc_freq = 8'h32;
			else if (src == link_selftest_pkg::CLK_OSC_LOW)
				osc_freq = 8'h19;
		end
		else if (src == link_selftest_pkg::CLK_OSC_HIGH)
		begin
			unique case (mode)
				link_selftest_pkg::MODE_10BIT: osc_freq = 8'h64;
				link_selftest_pkg::MODE_12BIT_HF: osc_freq = 8'h4B;
				default: osc_freq = 8'h32;
			endcase
		end
		else if (src == link_selftest_pkg::CLK_OSC_LOW)
		begin
			unique case (mode)
				link_selftest_pkg::MODE_10BIT: osc_freq = 8'h32;
				link_selftest_pkg::MODE_12BIT_HF: osc_freq = 8'h25;
				default: osc_freq = 8'h19;
			endcase
		end
	endfunction : osc_freq

	// pin setup by default, control register when its source bit is set
	assign st_req = ctrl_ff[`ST_CTRL_SRC_BIT] ? ctrl_ff[`ST_CTRL_EN_BIT]
		: selftest_enable_pin;
	assign clk_code = ctrl_ff[`ST_CTRL_SRC_BIT] ? ctrl_ff[`ST_CTRL_CLK_MSB:`ST_CTRL_CLK_LSB]
		: clk_sel_pins;
	assign check_en = (state_ff == link_selftest_pkg::ST_CHECK) && st_req;

	payload_checker u_checker (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst || !chip_enable_in),
		.check_en(check_en),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.word_valid(word_valid),
		.word_in(word_in),
		.frame_err(frame_err)
	);

	// control register; power-down acts as a device reset
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !chip_enable_in)
			ctrl_ff <= `ST_CTRL_RESET;
		else if (reg_wr && reg_addr == `ST_CTRL_ADDR)
			ctrl_ff <= reg_wdata & `ST_CTRL_MASK;
	end

	// registered read data; unmapped addresses read zero
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_addr == `ST_CTRL_ADDR)
			reg_rdata <= ctrl_ff;
		else if (reg_addr == `ST_ERRCNT_ADDR)
			reg_rdata <= errcnt_ff;
		else
			reg_rdata <= 8'h00;
	end

	// lock qualified by an active serial stream
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !chip_enable_in)
			locked_ff <= 1'b0;
		else
			locked_ff <= cdr_locked && serial_active;
	end

	// self-test sequencer
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			link_selftest_pkg::ST_OFF:
				if (st_req)
					nxt_state = link_selftest_pkg::ST_START;
			link_selftest_pkg::ST_START:
				if (!st_req)
					nxt_state = link_selftest_pkg::ST_OFF;
				else if (remote_in_selftest && locked_ff)
					nxt_state = link_selftest_pkg::ST_CHECK;
			link_selftest_pkg::ST_CHECK:
				if (!st_req)
					nxt_state = link_selftest_pkg::ST_RESULT;
			link_selftest_pkg::ST_RESULT:
				if (result_cnt_ff == 2'(`RESULT_CYC - 1))
					nxt_state = link_selftest_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !chip_enable_in)
			state_ff <= link_selftest_pkg::ST_OFF;
		else
			state_ff <= nxt_state;
	end

	// result window length in ref_clk cycles
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || state_ff != link_selftest_pkg::ST_RESULT)
			result_cnt_ff <= 2'b00;
		else
			result_cnt_ff <= result_cnt_ff + 2'b01;
	end

	// error frame count cleared at a new session, saturating so it never wraps to pass
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !chip_enable_in)
			errcnt_ff <= 8'h00;
		else if (state_ff == link_selftest_pkg::ST_OFF && st_req)
			errcnt_ff <= 8'h00;
		else if (frame_err && errcnt_ff != `ST_ERRCNT_MAX)
			errcnt_ff <= errcnt_ff + 8'h01;
	end

	// one cycle low per bad frame, i.e. one pixel period
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			err_pulse_ff <= 1'b0;
		else
			err_pulse_ff <= frame_err;
	end

	// back-channel command and run status
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !chip_enable_in)
		begin
			remote_selftest_cmd <= 1'b0;
			selftest_active <= 1'b0;
			selftest_clk_src <= link_selftest_pkg::CLK_PIXEL;
			selftest_freq_mhz <= 8'h00;
		end
		else
		begin
			remote_selftest_cmd <= (nxt_state == link_selftest_pkg::ST_START)
				|| (nxt_state == link_selftest_pkg::ST_CHECK);
			selftest_active <= nxt_state != link_selftest_pkg::ST_OFF;
			selftest_clk_src <= decode_clk(clk_code);
			selftest_freq_mhz <= osc_freq(decode_clk(clk_code), link_mode,
				ctrl_ff[`ST_CTRL_SRC_BIT]);
		end
	end

	// output state table; self-test owns the status pin in its check and result states
	always_comb
	begin
		nxt_out = '0;
		nxt_oe = '0;
		if (chip_enable_in)
		begin
			nxt_out.lock = locked_ff;
			nxt_oe.lock = output_drive_enable || locked_ff;
			if (!output_drive_enable)
			begin
				nxt_oe.status = !idle_output_state_select;
				nxt_oe.data = !idle_output_state_select;
				nxt_oe.clk = !idle_output_state_select;
			end
			else
			begin
				nxt_oe = '{lock: 1'b1, status: 1'b1, data: 1'b1, clk: 1'b1};
				if (!locked_ff)
				begin
					nxt_out.clk = !idle_output_state_select && ctrl_ff[`ST_CTRL_OSC_BIT]
						&& !pin_out.clk;
					nxt_out.status = idle_output_state_select && pin_out.status;
				end
				else if (idle_output_state_select)
				begin
					nxt_out.status = 1'b1;
					nxt_out.data = word_in;
					nxt_out.clk = pclk_in;
				end
			end
			// self-test status overrides the idle states in the check and result states
			if (state_ff == link_selftest_pkg::ST_CHECK)
			begin
				nxt_oe.status = 1'b1;
				nxt_out.status = !err_pulse_ff;
			end
			else if (state_ff == link_selftest_pkg::ST_RESULT)
			begin
				nxt_oe.status = 1'b1;
				nxt_out.status = errcnt_ff == 8'h00;
			end
		end
	end

	// all pins registered; chip enable low releases everything
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pin_out <= '0;
			pin_oe <= '0;
		end
		else
		begin
			pin_out <= nxt_out;
			pin_oe <= nxt_oe;
		end
	end
endmodule : link_output_selftest

// file: rtl/link_selftest_cfg.svh
// Purpose: constants for the link output state and self-test block
// Assumes: 20 MHz ref_clk, one ref_clk cycle stands for one pixel clock period
// Notes: offsets are the register addresses on the device programming port
`ifndef LINK_SELFTEST_CFG_SVH
`define LINK_SELFTEST_CFG_SVH

`define ST_CTRL_ADDR 8'h24
`define ST_ERRCNT_ADDR 8'h25
`define ST_CTRL_RESET 8'h00
`define ST_CTRL_EN_BIT 0
`define ST_CTRL_CLK_LSB 1
`define ST_CTRL_CLK_MSB 2
`define ST_CTRL_OSC_BIT 3
`define ST_CTRL_SRC_BIT 4
`define ST_CTRL_MASK 8'h1F
`define ST_ERRCNT_MAX 8'hFF
`define PCLK_PERIOD_NS 50
`define REF_PERIOD_NS 50
`define RESULT_CYC ((`PCLK_PERIOD_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define DATA_W 12

`endif

// file: rtl/link_selftest_pkg.sv
// Purpose: shared types for the link output state and self-test block
// Assumes: constants come from link_selftest_cfg.svh
// Notes: pin groups travel as packed structs
package link_selftest_pkg;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_START = 2'b01,
		ST_CHECK = 2'b10,
		ST_RESULT = 2'b11
	} selftest_state_e;

	// clock source picked for the self-test run
	typedef enum logic [1:0] {
		CLK_PIXEL = 2'b00,
		CLK_OSC_HIGH = 2'b01,
		CLK_OSC_LOW = 2'b10,
		CLK_RESERVED = 2'b11
	} selftest_clk_e;

	// payload width mode of the link
	typedef enum logic [1:0] {
		MODE_10BIT = 2'b00,
		MODE_12BIT_HF = 2'b01,
		MODE_12BIT_LF = 2'b10
	} link_mode_e;

	typedef struct packed {
		logic lock;
		logic status;
		logic [11:0] data;
		logic clk;
	} pin_out_s;

	typedef struct packed {
		logic lock;
		logic status;
		logic data;
		logic clk;
	} pin_oe_s;

endpackage : link_selftest_pkg

// file: rtl/payload_checker.sv
// Purpose: compares received payload with the expected test pattern per frame
// Assumes: pattern is a word count restarting at each frame start
// Notes: one error pulse per bad frame, raised at the frame end
`timescale 1ns/1ps
`include "link_selftest_cfg.svh"
module payload_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic check_en,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic word_valid,
	input wire logic [`DATA_W-1:0] word_in,
	output logic frame_err
);
	logic [`DATA_W-1:0] expect_ff;
	logic [`DATA_W-1:0] exp_word;
	logic bad_ff;
	logic word_bad;

	// the first word of a frame is compared against zero, not the old count
	assign exp_word = frame_start ? '0 : expect_ff;
	// any differing bit marks the word
	assign word_bad = word_valid && (word_in != exp_word);

	// expected pattern restarts with each frame
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			expect_ff <= '0;
		else if (word_valid)
			expect_ff <= exp_word + `DATA_W'(1);
	end

	// sticky error within the frame; a bad first or last word still counts
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !check_en || frame_end)
			bad_ff <= 1'b0;
		else if (frame_start)
			bad_ff <= word_bad;
		else if (word_bad)
			bad_ff <= 1'b1;
	end

	// each frame yields its own pulse so back to back errors stay countable
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			frame_err <= 1'b0;
		else
			frame_err <= check_en && frame_end && ((bad_ff && !frame_start) || word_bad);
	end
endmodule : payload_checker

// file: testbench/link_output_selftest_chk.sv
// Purpose: assertions on pin states and self-test control
// Assumes: one ref_clk domain; chip enable low clears state
// Notes: pins lag their cause by one register stage, the lock pin by two
`timescale 1ns/1ps
module link_output_selftest_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic chip_enable_in,
	input wire logic output_drive_enable,
	input wire logic idle_output_state_select,
	input wire logic selftest_enable_pin,
	input wire logic cdr_locked,
	input wire logic serial_active,
	input wire link_selftest_pkg::pin_out_s pin_out,
	input wire link_selftest_pkg::pin_oe_s pin_oe,
	input wire logic remote_selftest_cmd,
	input wire logic selftest_active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// two samples are needed: lock passes one flop before the pins
	sequence link_up_s;
		(chip_enable_in && output_drive_enable && cdr_locked && serial_active)[*2];
	endsequence
	sequence link_down_s;
		(chip_enable_in && output_drive_enable && !(cdr_locked && serial_active))[*2];
	endsequence
	sequence err_drop_s;
		selftest_active && remote_selftest_cmd && $fell(pin_out.status);
	endsequence
	a_ce_low_release: assert property (!chip_enable_in |=> pin_oe == 4'h0)
		else $error("pins driven while disabled");
	a_idle_drive_low: assert property (chip_enable_in && !output_drive_enable &&
		!idle_output_state_select && !selftest_active |=> pin_oe[2:0] == 3'h7 &&
		!pin_out.status && !pin_out.clk && pin_out.data == 12'h000)
		else $error("idle pins not driven low");
	a_idle_release: assert property (chip_enable_in && !output_drive_enable &&
		idle_output_state_select |=> pin_oe[2:0] == 3'h0)
		else $error("idle pins not released");
	a_lock_pin_oe: assert property (chip_enable_in && output_drive_enable |=> pin_oe.lock)
		else $error("lock pin not driven");
	a_unlocked_low: assert property (link_down_s |=> !pin_out.lock && pin_out.data == 12'h000)
		else $error("outputs not low while unlocked");
	a_locked_high: assert property (link_up_s |=> pin_out.lock)
		else $error("lock pin not high");
	a_cmd_on_start: assert property (chip_enable_in && $rose(selftest_enable_pin)
		|-> ##[1:2] remote_selftest_cmd && selftest_active)
		else $error("pattern command missing");
	a_err_pulse_one: assert property (err_drop_s |=> pin_out.status)
		else $error("error pulse not one cycle");
endmodule : link_output_selftest_chk

bind link_output_selftest link_output_selftest_chk chk_u (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .chip_enable_in(chip_enable_in),
	.output_drive_enable(output_drive_enable),
	.idle_output_state_select(idle_output_state_select),
	.selftest_enable_pin(selftest_enable_pin), .cdr_locked(cdr_locked),
	.serial_active(serial_active), .pin_out(pin_out), .pin_oe(pin_oe),
	.remote_selftest_cmd(remote_selftest_cmd), .selftest_active(selftest_active));

// file: testbench/serializer_model.sv
// Purpose: far-end serializer sending the counting test pattern
// Assumes: four-word frames with one idle cycle between frames
// Notes: corrupt spoils word 2 of every frame begun while it is high
`timescale 1ns/1ps
module serializer_model #(
	parameter int REPLY_CYC = 2
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic send_cmd,
	input wire logic corrupt,
	output logic remote_in_selftest,
	output logic frame_start,
	output logic frame_end,
	output logic word_valid,
	output logic [11:0] word_in
);
	logic [3:0] wait_ff;
	logic [2:0] phase_ff;
	logic bad_ff;
	logic [11:0] last_ff;
	// confirm the back-channel command only after a delay, drop at once
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || !send_cmd)
		begin
			wait_ff <= 4'h0;
			remote_in_selftest <= 1'b0;
		end
		else if (wait_ff == 4'(REPLY_CYC))
			remote_in_selftest <= 1'b1;
		else
			wait_ff <= wait_ff + 4'h1;
	end
	// corruption is latched in the gap so a frame is never half spoiled
	always_ff @(posedge ref_clk)
	begin
		phase_ff <= (!remote_in_selftest || phase_ff == 3'h4) ? 3'h0 : phase_ff + 3'h1;
		bad_ff <= sys_rst ? 1'b0 : (phase_ff == 3'h4) ? corrupt : bad_ff;
		last_ff <= sys_rst ? 12'h000 : word_valid ? word_in : last_ff;
	end
	assign word_valid = remote_in_selftest && phase_ff < 3'h4;
	assign frame_start = word_valid && phase_ff == 3'h0;
	assign frame_end = word_valid && phase_ff == 3'h3;
	// idle line shows the inverse of the last word, never a stale copy
	assign word_in = !word_valid ? ~last_ff :
		{9'h000, phase_ff} ^ {11'h000, bad_ff && phase_ff == 3'h2};
endmodule : serializer_model

// file: testbench/tb_link_output_selftest.sv
// Purpose: self-checking bench for pin states and self-test runs
// Assumes: inputs change 1 ns after each rising edge
// Notes: serializer_model plays the far end of the link
`timescale 1ns/1ps
module tb_link_output_selftest;
	logic ref_clk, sys_rst, ce, drv_en, idle_sel, st_pin, cdr, act, pclk, wr, corrupt;
	logic cmd, active, rem, fs, fe, wv, cnt_en, prev_st, osc_a;
	logic [1:0] clk_sel;
	logic [7:0] addr, wdata, rdata, freq;
	logic [11:0] word;
	logic [7:0] mhz_tab [4] = '{8'h64, 8'h4B, 8'h32, 8'h00};
	link_selftest_pkg::link_mode_e mode;
	link_selftest_pkg::pin_out_s pout;
	link_selftest_pkg::pin_oe_s poe;
	link_selftest_pkg::selftest_clk_e src;
	int fail_count = 0, samples_checked = 0, pulses = 0;
	link_output_selftest dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_enable_in(ce),
		.output_drive_enable(drv_en), .idle_output_state_select(idle_sel),
		.selftest_enable_pin(st_pin), .clk_sel_pins(clk_sel), .link_mode(mode),
		.cdr_locked(cdr), .serial_active(act), .remote_in_selftest(rem), .pclk_in(pclk),
		.frame_start(fs), .frame_end(fe), .word_valid(wv), .word_in(word), .reg_wr(wr),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .pin_out(pout),
		.pin_oe(poe), .remote_selftest_cmd(cmd), .selftest_clk_src(src),
		.selftest_freq_mhz(freq), .selftest_active(active));
	serializer_model far_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .send_cmd(cmd),
		.corrupt(corrupt), .remote_in_selftest(rem), .frame_start(fs),
		.frame_end(fe), .word_valid(wv), .word_in(word));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// count status falls while a run is watched
	always @(posedge ref_clk)
	begin
		if (cnt_en && prev_st && !pout.status)
			pulses++;
		prev_st <= pout.status;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
	endtask : reg_write
	task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		step(1);
		check(rdata, exp);
	endtask : reg_check
	// bounded so a silent far end cannot hang the run
	task automatic wait_fe;
		int n;
		n = 0;
		do
		begin
			step(1);
			n++;
		end
		while (fe !== 1'b1 && n < 50);
	endtask : wait_fe
	task automatic run_pin(input logic [1:0] c, input int nbad, input logic [7:0] mhz);
		clk_sel = c;
		st_pin = 1'b1;
		step(10);
		check(8'({cmd, active, pout.status}), 8'h07);
		check(8'(src), 8'(c));
		check(freq, mhz);
		pulses = 0;
		cnt_en = 1'b1;
		wait_fe();
		corrupt = nbad != 0;
		repeat (nbad) wait_fe();
		corrupt = 1'b0;
		step(8);
		st_pin = 1'b0;
		step(6);
		cnt_en = 1'b0;
		check(8'(pulses), 8'(nbad + (nbad != 0)));
		check(8'({cmd, active}), 8'h00);
		reg_check(8'h25, 8'(nbad));
	endtask : run_pin
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		{ce, drv_en, idle_sel, st_pin, cdr, act, pclk, wr, corrupt, cnt_en} = '0;
		{clk_sel, addr, wdata} = '0;
		mode = link_selftest_pkg::MODE_10BIT;
		sys_rst = 1'b1;
		step(8);
		sys_rst = 1'b0;
		reg_check(8'h24, 8'h00);
		reg_check(8'h30, 8'h00);
		reg_write(8'h25, 8'h5A);
		reg_check(8'h25, 8'h00);
		// link down: each drive enable and idle select, then chip off
		for (int i = 0; i < 5; i++)
		begin
			{ce, drv_en, idle_sel} = (i == 4) ? 3'b000 : {1'b1, 2'(i)};
			step(3);
			check(8'(poe), (i == 4) ? 8'h00 : {4'h0, drv_en, {3{drv_en | !idle_sel}}});
			check(8'({pout.lock, pout.status, pout.data != 12'h000}), 8'h00);
		end
		// unlocked, idle select 0: oscillation bit toggles the clock pin
		{ce, drv_en} = 2'b11;
		reg_write(8'h24, 8'hE8);
		reg_check(8'h24, 8'h08);
		step(1);
		osc_a = pout.clk;
		step(1);
		check(8'(osc_a ^ pout.clk), 8'h01);
		reg_write(8'h24, 8'h00);
		{ce, drv_en, idle_sel, cdr, act, pclk} = 6'h3F;
		step(4);
		check(8'({pout.lock, pout.clk, poe}), 8'h3F);
		idle_sel = 1'b0;
		step(3);
		check(8'({pout.status, pout.clk, pout.data != 12'h000}), 8'h00);
		idle_sel = 1'b1;
		step(3);
		run_pin(2'b00, 0, 8'h00);
		run_pin(2'b01, 2, 8'h32);
		run_pin(2'b10, 0, 8'h19);
		// register source: code 01 in each payload mode, then the reserved code
		for (int m = 0; m < 4; m++)
		begin
			mode = link_selftest_pkg::link_mode_e'((m == 3) ? 0 : m);
			reg_write(8'h24, (m == 3) ? 8'h17 : 8'h13);
			step(3);
			check(8'(cmd), 8'h01);
			check(freq, mhz_tab[m]);
			check(8'(src), (m == 3) ? 8'h03 : 8'h01);
			reg_check(8'h24, (m == 3) ? 8'h17 : 8'h13);
			reg_write(8'h24, 8'h10);
			step(6);
		end
		give_verdict();
	end
	// tests take about 190 cycles; far beyond that is a hang
	initial
	begin
		#(50 * 12000);
		fail_count++;
		give_verdict();
	end
endmodule : tb_link_output_selftest
